// >>> logic/tef_frontend.v
`timescale 1ns/1ps
`include "tef_regs.vh"
module tef_frontend #(
  parameter [1:0] DENSITY = `TEF_DENS_2K,
  parameter integer WR_CYCLES = `TEF_WR_TIME_MS * `TEF_CLK_KHZ
) (
  input wire ref_clk,
  input wire rstn,
  input wire sclPin,
  input wire sdaIn,
  output wire sdaOut,
  output wire sdaOe,
  input wire chip_select_bit_high,
  input wire chip_select_bit_mid,
  input wire chip_select_bit_low,
  input wire [7:0] txData,
  output wire txNext,
  output wire [7:0] rxByte,
  output wire rxValid,
  output wire addrMatch,
  output wire rwBit,
  output wire [2:0] pageBits,
  output wire standby,
  output wire writeBusy
);
  // one-hot states
  localparam [8:0] ST_IDLE = 9'h001;
  localparam [8:0] ST_ADDR = 9'h002;
  localparam [8:0] ST_AACK = 9'h004;
  localparam [8:0] ST_WRX = 9'h008;
  localparam [8:0] ST_WACK = 9'h010;
  localparam [8:0] ST_TX = 9'h020;
  localparam [8:0] ST_TACK = 9'h040;
  localparam [8:0] ST_WAIT = 9'h080;
  localparam [8:0] ST_BUSY = 9'h100;
  // timer load value for the write cycle
  localparam [31:0] WR_LOAD_FULL = WR_CYCLES - 1;
  // cut to the timer width on purpose; the default count fits in it
  localparam [`TEF_TIMER_W-1:0] WR_LOAD = WR_LOAD_FULL[`TEF_TIMER_W-1:0];

  // synchronised bus lines and straps
  wire [1:0] busSync;
  wire [2:0] strapSync;
  wire sclS = busSync[1];
  wire sdaS = busSync[0];
  // previous samples for edge detection
  reg sclD_reg;
  reg sdaD_reg;
  // control state
  reg [8:0] state_reg;
  reg [8:0] state_next;
  reg [3:0] bitCnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] txShift_reg;
  reg oe_reg;
  reg ackSeen_reg;
  reg wrPend_reg;
  reg [`TEF_TIMER_W-1:0] timer_reg;
  // registered outputs
  reg sdaOut_reg;
  reg txNext_reg;
  reg rxValid_reg;
  reg addrMatch_reg;
  reg rwBit_reg;
  reg [2:0] pageBits_reg;
  reg [7:0] rxByte_reg;
  reg standby_reg;
  reg busy_reg;
  // compare mask for the chosen density
  reg [2:0] selMask;

  // scl and sda idle high, straps idle low
  tef_sync #(.WIDTH(2), .RESET_VAL(`TEF_BUS_IDLE)) busSyncInst (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .din({sclPin, sdaIn}),
    .dout(busSync)
  );
  tef_sync #(.WIDTH(3), .RESET_VAL(`TEF_STRAP_IDLE)) strapSyncInst (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .din({chip_select_bit_high, chip_select_bit_mid, chip_select_bit_low}),
    .dout(strapSync)
  );

  // edges of the bus clock and bus conditions
  wire sclRise = sclS & ~sclD_reg;
  wire sclFall = ~sclS & sclD_reg;
  // any data change while clock high is a condition, never data
  wire startCond = sclS & sclD_reg & sdaD_reg & ~sdaS;
  wire stopCond = sclS & sclD_reg & ~sdaD_reg & sdaS;
  // a full word has been sampled
  wire wordDone = (bitCnt_reg == `TEF_BITS_PER_WORD);

  // select bits compared per density
  always @*
  begin
    case (DENSITY)
      `TEF_DENS_2K: selMask = `TEF_MASK_2K;
      `TEF_DENS_4K: selMask = `TEF_MASK_4K;
      `TEF_DENS_8K: selMask = `TEF_MASK_8K;
      default: selMask = `TEF_MASK_16K;
    endcase
  end

  // address word compare: type code plus masked select bits
  wire typeOk = (shift_reg[`TEF_TYPE_MSB:`TEF_TYPE_LSB] == `TEF_TYPE_CODE);
  wire selOk = (((shift_reg[`TEF_SEL_MSB:`TEF_SEL_LSB] ^ strapSync) & selMask) == 3'h0);
  wire addrOk = typeOk & selOk;

  // next state
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_BUSY:
      begin
        // bus fully ignored until the cycle is over
        if (timer_reg == {`TEF_TIMER_W{1'b0}})
          state_next = ST_IDLE;
      end
      default:
      begin
        if (startCond)
          state_next = ST_ADDR;
        else if (stopCond)
          state_next = wrPend_reg ? ST_BUSY : ST_IDLE;
        else
        begin
          case (state_reg)
            ST_ADDR:
            begin
              // mismatch drops back to standby without an ack
              if (sclFall && wordDone)
                state_next = addrOk ? ST_AACK : ST_IDLE;
            end
            ST_AACK:
            begin
              if (sclFall)
                state_next = shift_reg[`TEF_RW_BIT] ? ST_TX : ST_WRX;
            end
            ST_WRX:
            begin
              if (sclFall && wordDone)
                state_next = ST_WACK;
            end
            ST_WACK:
            begin
              if (sclFall)
                state_next = ST_WRX;
            end
            ST_TX:
            begin
              if (sclFall && wordDone)
                state_next = ST_TACK;
            end
            ST_TACK:
            begin
              // controller nack ends the read until the next start or stop
              if (sclFall)
                state_next = ackSeen_reg ? ST_TX : ST_WAIT;
            end
            ST_IDLE: state_next = ST_IDLE;
            ST_WAIT: state_next = ST_WAIT;
            default: state_next = ST_IDLE;
          endcase
        end
      end
    endcase
  end

  // edge history
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sclD_reg <= 1'b1;
      sdaD_reg <= 1'b1;
    end
    else
    begin
      sclD_reg <= sclS;
      sdaD_reg <= sdaS;
    end
  end

  // datapath, pin drive and timer
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= ST_IDLE;
      bitCnt_reg <= `TEF_CNT_ZERO;
      shift_reg <= 8'h00;
      txShift_reg <= 8'h00;
      oe_reg <= 1'b0;
      ackSeen_reg <= 1'b0;
      wrPend_reg <= 1'b0;
      timer_reg <= {`TEF_TIMER_W{1'b0}};
      sdaOut_reg <= 1'b0;
      txNext_reg <= 1'b0;
      rxValid_reg <= 1'b0;
      addrMatch_reg <= 1'b0;
      rwBit_reg <= 1'b0;
      pageBits_reg <= 3'h0;
      rxByte_reg <= 8'h00;
      standby_reg <= 1'b1;
      busy_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      // the pin only ever pulls low; high comes from the pull-up
      sdaOut_reg <= 1'b0;
      txNext_reg <= 1'b0;
      rxValid_reg <= 1'b0;
      addrMatch_reg <= 1'b0;
      standby_reg <= (state_next == ST_IDLE);
      busy_reg <= (state_next == ST_BUSY);
      if (state_reg == ST_BUSY)
      begin
        // self-timed cycle counts down on the core clock
        if (timer_reg != {`TEF_TIMER_W{1'b0}})
          timer_reg <= timer_reg - {{(`TEF_TIMER_W-1){1'b0}}, 1'b1};
        oe_reg <= 1'b0;
      end
      else if (startCond)
      begin
        // a new transaction always begins with the address word
        bitCnt_reg <= `TEF_CNT_ZERO;
        oe_reg <= 1'b0;
        wrPend_reg <= wrPend_reg;
      end
      else if (stopCond)
      begin
        oe_reg <= 1'b0;
        bitCnt_reg <= `TEF_CNT_ZERO;
        if (wrPend_reg)
          timer_reg <= WR_LOAD;
        wrPend_reg <= 1'b0;
      end
      else
      begin
        // sampling of incoming bits on the rising edge
        if (sclRise && ((state_reg == ST_ADDR) || (state_reg == ST_WRX)))
        begin
          shift_reg <= {shift_reg[6:0], sdaS};
          bitCnt_reg <= bitCnt_reg + `TEF_CNT_ONE;
        end
        // outgoing bits counted on the rising edge
        if (sclRise && (state_reg == ST_TX))
          bitCnt_reg <= bitCnt_reg + `TEF_CNT_ONE;
        // controller acknowledge after a sent word
        if (sclRise && (state_reg == ST_TACK))
          ackSeen_reg <= ~sdaS;
        if (sclFall)
        begin
          case (state_reg)
            ST_ADDR:
            begin
              if (wordDone && addrOk)
              begin
                oe_reg <= 1'b1;
                addrMatch_reg <= 1'b1;
                rwBit_reg <= shift_reg[`TEF_RW_BIT];
                // unused select positions carry page bits
                pageBits_reg <= shift_reg[`TEF_SEL_MSB:`TEF_SEL_LSB] & ~selMask;
              end
            end
            ST_AACK:
            begin
              // release after the ninth clock, or start sending
              bitCnt_reg <= `TEF_CNT_ZERO;
              txShift_reg <= txData;
              oe_reg <= shift_reg[`TEF_RW_BIT] & ~txData[7];
            end
            ST_WRX:
            begin
              if (wordDone)
              begin
                oe_reg <= 1'b1;
                rxByte_reg <= shift_reg;
                rxValid_reg <= 1'b1;
                wrPend_reg <= 1'b1;
              end
            end
            ST_WACK:
            begin
              oe_reg <= 1'b0;
              bitCnt_reg <= `TEF_CNT_ZERO;
            end
            ST_TX:
            begin
              if (wordDone)
              begin
                // release for the controller's acknowledge
                oe_reg <= 1'b0;
                txNext_reg <= 1'b1;
              end
              else
              begin
                txShift_reg <= {txShift_reg[6:0], 1'b0};
                oe_reg <= ~txShift_reg[6];
              end
            end
            ST_TACK:
            begin
              bitCnt_reg <= `TEF_CNT_ZERO;
              txShift_reg <= txData;
              oe_reg <= ackSeen_reg & ~txData[7];
            end
            default:
            begin
              oe_reg <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  assign sdaOut = sdaOut_reg;
  assign sdaOe = oe_reg;
  assign txNext = txNext_reg;
  assign rxByte = rxByte_reg;
  assign rxValid = rxValid_reg;
  assign addrMatch = addrMatch_reg;
  assign rwBit = rwBit_reg;
  assign pageBits = pageBits_reg;
  assign standby = standby_reg;
  assign writeBusy = busy_reg;
endmodule

// >>> logic/tef_regs.vh
`ifndef TEF_REGS_VH
`define TEF_REGS_VH
// fixed device-type code in the upper nibble of the address word
`define TEF_TYPE_CODE 4'hA
// density codes for the DENSITY parameter
`define TEF_DENS_2K 2'h0
`define TEF_DENS_4K 2'h1
`define TEF_DENS_8K 2'h2
`define TEF_DENS_16K 2'h3
// which select positions are compared with the strap inputs
`define TEF_MASK_2K 3'h7
`define TEF_MASK_4K 3'h6
`define TEF_MASK_8K 3'h4
`define TEF_MASK_16K 3'h0
// word length in bits, counted on rising bus clock edges
`define TEF_BITS_PER_WORD 4'h8
`define TEF_CNT_ZERO 4'h0
`define TEF_CNT_ONE 4'h1
// address word field positions
`define TEF_TYPE_MSB 7
`define TEF_TYPE_LSB 4
`define TEF_SEL_MSB 3
`define TEF_SEL_LSB 1
`define TEF_RW_BIT 0
// self-timed write cycle, in ms, and the core clock in kHz
`define TEF_WR_TIME_MS 5
`define TEF_CLK_KHZ 50000
`define TEF_TIMER_W 18
// idle level of the bus lines and of the strap inputs
`define TEF_BUS_IDLE 2'h3
`define TEF_STRAP_IDLE 3'h0
`endif

// >>> logic/tef_sync.v
`timescale 1ns/1ps
// two-flop synchroniser for pins from outside the core clock domain
module tef_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire ref_clk,
  input wire rstn,
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  // first stage, read only by the second stage
  reg [WIDTH-1:0] meta_reg;
  // second stage, safe to use
  reg [WIDTH-1:0] stable_reg;

  // both stages reset to the idle level of the line
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_reg <= RESET_VAL;
      stable_reg <= RESET_VAL;
    end
    else
    begin
      meta_reg <= din;
      stable_reg <= meta_reg;
    end
  end

  assign dout = stable_reg;
endmodule

// >>> test/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
// front end against a controller model, strap value 5
module tb_top;
  reg ref_clk = 1'b0;
  reg rstn;
  reg [2:0] strap;
  reg [7:0] txData;
  wire sclPin, sdaLow, sdaWire, sdaOut, sdaOe, txNext, rxValid;
  wire addrMatch, rwBit, standby, writeBusy;
  wire [7:0] rxByte;
  wire [2:0] pageBits;
  integer fails, samplesChecked, cycles;
  reg sawMatch, ack;
  reg [7:0] rxLast, d;
  // wired line with pull-up
  assign sdaWire = !(sdaLow || (sdaOe && !sdaOut));
  always #10 ref_clk = ~ref_clk;
  tef_frontend #(.DENSITY(2'h0), .WR_CYCLES(400)) u_tef_frontend (
    .ref_clk(ref_clk), .rstn(rstn), .sclPin(sclPin), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .chip_select_bit_high(strap[2]), .chip_select_bit_mid(strap[1]), .chip_select_bit_low(strap[0]),
    .txData(txData), .txNext(txNext), .rxByte(rxByte), .rxValid(rxValid), .addrMatch(addrMatch),
    .rwBit(rwBit), .pageBits(pageBits), .standby(standby), .writeBusy(writeBusy));
  tef_ctl_model u_tef_ctl_model (.scl(sclPin), .sdaLow(sdaLow), .sdaWire(sdaWire));
  // pulse capture, next read word, hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (addrMatch) sawMatch <= 1'b1;
    if (rxValid) rxLast <= rxByte;
    if (txNext) txData <= ~txData;
    if (cycles == 30000)
    begin
      fails++;
      results;
    end
  end
  task automatic results();
    if (fails == 0 && samplesChecked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // start plus address word, answer compared
  task automatic sendAddr(input logic [7:0] a, input logic e);
    sawMatch = 1'b0;
    u_tef_ctl_model.start();
    u_tef_ctl_model.byteTx(a, ack);
    `CHK(ack, e)
  endtask
  task automatic tReset();
    `CHK(standby, 1'b1)
    `CHK(sdaOe, 1'b0)
  endtask
  task automatic tWrite();
    integer i;
    sendAddr({4'hA, strap, 1'b0}, 1'b1);
    `CHK(sawMatch, 1'b1)
    `CHK(rwBit, 1'b0)
    `CHK(pageBits, 3'h0)
    `CHK(standby, 1'b0)
    u_tef_ctl_model.byteTx(8'h5A, ack);
    `CHK(ack, 1'b1)
    `CHK(rxLast, 8'h5A)
    u_tef_ctl_model.stop();
    repeat (4) @(posedge ref_clk);
    `CHK(writeBusy, 1'b1)
    sendAddr({4'hA, strap, 1'b0}, 1'b0);
    u_tef_ctl_model.stop();
    for (i = 0; i < 1000 && writeBusy; i++) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
    `CHK(writeBusy, 1'b0)
    `CHK(standby, 1'b1)
  endtask
  task automatic tMismatch();
    integer i;
    reg [7:0] a [0:3];
    a[0] = {4'hA, strap ^ 3'h1, 1'b0};
    a[1] = {4'hA, strap ^ 3'h2, 1'b1};
    a[2] = {4'hA, strap ^ 3'h4, 1'b0};
    a[3] = {4'hB, strap, 1'b0};
    for (i = 0; i < 4; i++)
    begin
      sendAddr(a[i], 1'b0);
      `CHK(sawMatch, 1'b0)
      `CHK(standby, 1'b1)
      u_tef_ctl_model.recover();
    end
    u_tef_ctl_model.stop();
  endtask
  task automatic tRead();
    @(posedge ref_clk) txData <= 8'hC3;
    sendAddr({4'hA, strap, 1'b0}, 1'b1);
    sendAddr({4'hA, strap, 1'b1}, 1'b1);
    `CHK(rwBit, 1'b1)
    u_tef_ctl_model.byteRx(1'b1, d);
    `CHK(d, 8'hC3)
    u_tef_ctl_model.byteRx(1'b0, d);
    `CHK(d, 8'h3C)
    u_tef_ctl_model.stop();
    repeat (4) @(posedge ref_clk);
    `CHK(standby, 1'b1)
    `CHK(writeBusy, 1'b0)
  endtask
  initial
  begin
    rstn = 1'b0;
    strap = 3'h5;
    txData = 8'h00;
    fails = 0;
    samplesChecked = 0;
    cycles = 0;
    sawMatch = 1'b0;
    rxLast = 8'h00;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    tReset();
    tWrite();
    tMismatch();
    tRead();
    results();
  end
endmodule

// >>> test/tef_ctl_model.sv
`timescale 1ns/1ps
// bus controller model: clocks the bus and only ever pulls data low
module tef_ctl_model #(
  parameter integer Q = 40
) (
  output reg scl,
  output reg sdaLow,
  input wire sdaWire
);
  // clock stands high and data is released between frames
  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // one clock: data set mid low phase, sampled mid high phase
  task automatic bitx(input logic b, output logic r);
    #Q sdaLow = !b;
    #Q scl = 1'b1;
    #Q r = sdaWire;
    #Q scl = 1'b0;
  endtask
  // start, also usable as a repeated start
  task automatic start();
    #7 sdaLow = 1'b0;
    #Q scl = 1'b1;
    #Q sdaLow = 1'b1;
    #Q scl = 1'b0;
  endtask
  // stop leaves both lines high
  task automatic stop();
    #Q sdaLow = 1'b1;
    #Q scl = 1'b1;
    #Q sdaLow = 1'b0;
    #Q;
  endtask
  // word out msb first, then the answer bit
  task automatic byteTx(input logic [7:0] d, output logic ack);
    integer i;
    logic r;
    for (i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  // word in, then our own answer
  task automatic byteRx(input logic ackIt, output logic [7:0] d);
    integer i;
    logic r;
    for (i = 7; i >= 0; i--)
      bitx(1'b1, d[i]);
    bitx(!ackIt, r);
  endtask
  // nine released clocks to free a stuck bus
  task automatic recover();
    logic r;
    repeat (9) bitx(1'b1, r);
  endtask
endmodule

// >>> test/tef_frontend_monitor.sv
`timescale 1ns/1ps
// watches the front end pins and flags broken bus behaviour
module tef_frontend_monitor #(
  parameter [1:0] DENSITY = 2'h0,
  parameter integer WR_CYCLES = 50
) (
  input wire ref_clk,
  input wire rstn,
  input wire sclPin,
  input wire sdaIn,
  input wire sdaOut,
  input wire sdaOe,
  input wire chip_select_bit_high,
  input wire chip_select_bit_mid,
  input wire chip_select_bit_low,
  input wire [7:0] txData,
  input wire txNext,
  input wire [7:0] rxByte,
  input wire rxValid,
  input wire addrMatch,
  input wire rwBit,
  input wire [2:0] pageBits,
  input wire standby,
  input wire writeBusy
);
  // length of the running write cycle in core clocks
  reg [17:0] busyCnt_reg;
  // counts while busy, clears otherwise
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      busyCnt_reg <= 18'h0_0000;
    else if (writeBusy)
      busyCnt_reg <= busyCnt_reg + 18'h0_0001;
    else
      busyCnt_reg <= 18'h0_0000;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  chk_never_high: assert property (sdaOut == 1'b0)
    else $error("data line driven high");
  chk_busy_silent: assert property (writeBusy |-> !sdaOe)
    else $error("acknowledge during write cycle");
  chk_busy_awake: assert property (writeBusy |-> !standby)
    else $error("standby during write cycle");
  chk_busy_length: assert property ($fell(writeBusy) |-> busyCnt_reg == WR_CYCLES)
    else $error("write cycle length wrong");
  chk_busy_sleep: assert property ($fell(writeBusy) |-> ##[0:2] standby)
    else $error("no standby after write cycle");
  chk_addr_ack: assert property (addrMatch |-> ##[0:2] sdaOe)
    else $error("matching address not acknowledged");
  chk_addr_wake: assert property (addrMatch |-> ##[0:2] !standby)
    else $error("standby after matching address");
  chk_data_ack: assert property (rxValid |-> ##[0:2] sdaOe)
    else $error("data word not acknowledged");
  chk_ack_held: assert property ($rose(sdaOe) |=> sdaOe[*6])
    else $error("data line pull too short");
  chk_no_pages: assert property (DENSITY != 2'h0 || pageBits == 3'h0)
    else $error("page bits set in smallest density");
endmodule

bind tef_frontend tef_frontend_monitor #(.DENSITY(DENSITY), .WR_CYCLES(WR_CYCLES)) u_tef_frontend_monitor (
  .ref_clk(ref_clk), .rstn(rstn), .sclPin(sclPin), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .chip_select_bit_high(chip_select_bit_high), .chip_select_bit_mid(chip_select_bit_mid),
  .chip_select_bit_low(chip_select_bit_low), .txData(txData), .txNext(txNext), .rxByte(rxByte),
  .rxValid(rxValid), .addrMatch(addrMatch), .rwBit(rwBit), .pageBits(pageBits), .standby(standby),
  .writeBusy(writeBusy));
